// [src/smcm_core.sv]
// mode sequencer and command mailbox of the light sensor
`timescale 1ns/1ps
module smcm_core #(
    parameter int INIT_CYCLES      = smcm_pkg::INIT_CYCLES_DEF,
    parameter int WAKE_UNIT_CYCLES = smcm_pkg::WAKE_UNIT_CYC_DEF
) (
    // core clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // link clock and host mailbox
    input  wire logic        link_clk,
    input  wire logic        host_cmd_wr,
    input  wire logic [7:0]  host_cmd_code,
    input  wire logic [7:0]  host_param_in,
    input  wire logic        host_gen_reset,
    output logic      [7:0]  host_resp,
    output logic      [7:0]  host_param_out,
    // interrupt control and open-drain pin
    input  wire logic        irq_enable,
    input  wire logic        irq_clear,
    output logic             int_level,
    output logic             int_oe,
    // conversion engine
    output logic             adc_start,
    output logic      [1:0]  adc_chan,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_data,
    // results and status
    output logic      [15:0] result_visible,
    output logic      [15:0] result_infrared,
    output logic      [15:0] result_third,
    output logic             seq_awake,
    output logic             auto_active
);

    localparam int TW = smcm_pkg::TMR_W;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_INIT,
        ST_STANDBY,
        ST_EXEC,
        ST_MEAS_REQ,
        ST_MEAS_WAIT
    } smcm_seq_t;

    typedef struct packed {
        smcm_seq_t                         st;
        logic [2:0]                        req_sync;
        logic [2:0]                        gcr_sync;
        logic                              req_pend;
        logic [TW-1:0]                     tmr;
        logic                              auto_on;
        logic [1:0]                        ch;
        logic [7:0]                        resp;
        logic [7:0]                        pout;
        logic [smcm_pkg::PRAM_DEPTH-1:0][7:0] pram;
        logic [smcm_pkg::NUM_CH-1:0][15:0]    res;
        logic                              irq_pend;
        logic                              int_level;
        logic                              adc_start;
        logic [1:0]                        adc_chan;
        logic                              upd_tgl;
        logic                              seq_awake;
    } smcm_core_state_t;

    smcm_core_state_t q;
    smcm_core_state_t d;

    logic [7:0]    cmd_code;
    logic [7:0]    param_in;
    logic          req_tgl;
    logic          gcr_tgl;
    logic          req_ev;
    logic          gcr_ev;
    logic [4:0]    cmd_idx;
    logic [2:0]    cmd_op;
    logic [7:0]    wake_ival;
    logic [7:0]    chsel;
    logic [TW-1:0] period;
    logic [7:0]    resp_bump;

    ////////////////////////////////////////////////////////////////////////////
    // link-side mailbox
    smcm_link u_link (
        .link_clk       (link_clk),
        .srst           (srst),
        .host_cmd_wr    (host_cmd_wr),
        .host_cmd_code  (host_cmd_code),
        .host_param_in  (host_param_in),
        .host_gen_reset (host_gen_reset),
        .host_resp      (host_resp),
        .host_param_out (host_param_out),
        .cmd_code       (cmd_code),
        .param_in       (param_in),
        .req_tgl        (req_tgl),
        .gcr_tgl        (gcr_tgl),
        .core_resp      (q.resp),
        .core_pout      (q.pout),
        .upd_tgl        (q.upd_tgl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    assign req_ev    = q.req_sync[2] ^ q.req_sync[1];
    assign gcr_ev    = q.gcr_sync[2] ^ q.gcr_sync[1];
    assign cmd_idx   = cmd_code[smcm_pkg::IDX_MSB:0];
    assign cmd_op    = cmd_code[smcm_pkg::OP_MSB:smcm_pkg::OP_LSB];
    assign wake_ival = q.pram[smcm_pkg::PIDX_WAKE_INTERVAL];
    assign chsel     = q.pram[smcm_pkg::PIDX_CHANNEL_SELECT];
    assign period    = TW'(wake_ival) * TW'(WAKE_UNIT_CYCLES);
    // counter advances only while no error is shown
    assign resp_bump = (q.resp[7:4] == smcm_pkg::RESP_NO_ERROR) ?
                       {smcm_pkg::RESP_NO_ERROR, q.resp[3:0] + smcm_pkg::RESP_COUNT_STEP} :
                       q.resp;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d           = q;
        d.req_sync  = {q.req_sync[1:0], req_tgl};
        d.gcr_sync  = {q.gcr_sync[1:0], gcr_tgl};
        d.adc_start = 1'b0;
        d.int_level = 1'b0;
        if (q.tmr != '0) begin
            d.tmr = q.tmr - TW'(1);
        end
        if (req_ev) begin
            d.req_pend = 1'b1;
        end
        // host clear; a completing pass below still wins
        if (irq_clear) begin
            d.irq_pend = 1'b0;
        end
        case (q.st)
            ST_OFF: begin
                d.resp     = '0;
                d.pout     = '0;
                d.pram     = '0;
                d.res      = '0;
                d.irq_pend = 1'b0;
                d.auto_on  = 1'b0;
                d.req_pend = 1'b0;
                d.upd_tgl  = ~q.upd_tgl;
                d.tmr      = TW'(INIT_CYCLES);
                d.st       = ST_INIT;
            end
            ST_INIT: begin
                if (q.tmr == '0) begin
                    d.st = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (q.req_pend) begin
                    d.req_pend = req_ev;
                    d.st       = ST_EXEC;
                end else if (q.auto_on && (wake_ival != '0) && (q.tmr == '0)) begin
                    d.tmr = period;
                    d.ch  = smcm_pkg::CH_VISIBLE;
                    d.st  = ST_MEAS_REQ;
                end
            end
            ST_EXEC: begin
                d.st      = ST_STANDBY;
                d.upd_tgl = ~q.upd_tgl;
                if (cmd_code == smcm_pkg::CMD_CLEAR_RESPONSE) begin
                    d.resp = '0;
                end else if (cmd_code == smcm_pkg::CMD_RESET) begin
                    d.upd_tgl = q.upd_tgl;
                    d.st      = ST_OFF;
                end else if (cmd_code == smcm_pkg::CMD_SINGLE_MEASURE) begin
                    d.resp = resp_bump;
                    d.ch   = smcm_pkg::CH_VISIBLE;
                    d.st   = ST_MEAS_REQ;
                end else if (cmd_code == smcm_pkg::CMD_PAUSE_LOOP) begin
                    d.resp    = resp_bump;
                    d.auto_on = 1'b0;
                end else if (cmd_code == smcm_pkg::CMD_AUTONOMOUS_LOOP) begin
                    d.resp    = resp_bump;
                    d.auto_on = 1'b1;
                    d.tmr     = '0;
                end else if (cmd_op == smcm_pkg::OP_PARAM_READ) begin
                    d.resp = resp_bump;
                    d.pout = q.pram[cmd_idx];
                end else if (cmd_op == smcm_pkg::OP_PARAM_WRITE) begin
                    d.resp          = resp_bump;
                    d.pram[cmd_idx] = param_in;
                    d.pout          = param_in;
                end else begin
                    d.upd_tgl = q.upd_tgl;
                end
            end
            ST_MEAS_REQ: begin
                if (q.ch == smcm_pkg::CH_DONE) begin
                    if (irq_enable) begin
                        d.irq_pend = 1'b1;
                    end
                    d.st = ST_STANDBY;
                end else if (chsel[smcm_pkg::CHSEL_LSB + int'(q.ch)]) begin
                    d.adc_start = 1'b1;
                    d.adc_chan  = q.ch;
                    d.st        = ST_MEAS_WAIT;
                end else begin
                    d.ch = q.ch + 2'h1;
                end
            end
            ST_MEAS_WAIT: begin
                if (adc_done) begin
                    d.res[q.ch] = adc_data;
                    if (adc_data == smcm_pkg::ADC_OVERFLOW) begin
                        d.resp    = smcm_pkg::RESP_OVF_BASE + {6'h00, q.ch};
                        d.upd_tgl = ~q.upd_tgl;
                    end
                    d.ch = q.ch + 2'h1;
                    d.st = ST_MEAS_REQ;
                end
            end
            default: begin
                d.st = ST_OFF;
            end
        endcase
        if (gcr_ev) begin
            d.st = ST_OFF;
        end
        // sequencer sleeps only in standby
        d.seq_awake = (d.st != ST_STANDBY);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign int_level       = q.int_level;
    assign int_oe          = q.irq_pend;
    assign adc_start       = q.adc_start;
    assign adc_chan        = q.adc_chan;
    assign result_visible  = q.res[0];
    assign result_infrared = q.res[1];
    assign result_third    = q.res[2];
    assign seq_awake       = q.seq_awake;
    assign auto_active     = q.auto_on;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_exec_reset;
        (q.st == ST_EXEC) && (cmd_code == smcm_pkg::CMD_RESET) && !gcr_ev;
    endsequence

    sequence s_off_then_init;
        (q.st == ST_OFF) ##1 (q.st == ST_INIT) && (q.resp == '0);
    endsequence

    sequence s_exec_single;
        (q.st == ST_EXEC) && (cmd_code == smcm_pkg::CMD_SINGLE_MEASURE) && !gcr_ev;
    endsequence

    AST_GEN_RESET_OFF: assert property (gcr_ev |=> s_off_then_init)
        else $error("general reset did not pass through off into init");

    AST_INIT_TO_STANDBY: assert property (
        (q.st == ST_INIT) && (q.tmr == '0) && !gcr_ev |=> (q.st == ST_STANDBY))
        else $error("init did not end in standby");

    AST_NO_ADC_ASLEEP: assert property (adc_start |-> (q.st == ST_MEAS_WAIT) && seq_awake)
        else $error("conversion started while asleep");

    AST_IRQ_HOLDS: assert property ($fell(int_oe) |-> $past(irq_clear) || $past(q.st == ST_OFF))
        else $error("interrupt dropped without a clear");

    AST_STAY_ASLEEP: assert property (
        (q.st == ST_STANDBY) && !q.req_pend && !req_ev && !gcr_ev
        && (!q.auto_on || (wake_ival == '0)) |=> (q.st == ST_STANDBY))
        else $error("sequencer woke without a command or wake-up");

    AST_SINGLE_PASS: assert property (
        s_exec_single |=> (q.st == ST_MEAS_REQ) && (q.ch == smcm_pkg::CH_VISIBLE))
        else $error("single measure did not start a pass");

    AST_RESULT_STORED: assert property (
        (q.st == ST_MEAS_WAIT) && adc_done && !gcr_ev
        |=> (q.res[$past(q.ch)] == $past(adc_data)))
        else $error("result not stored in its register");

    AST_COUNT_STEP: assert property (
        s_exec_single and (q.resp[7:4] == smcm_pkg::RESP_NO_ERROR)
        |=> (q.resp[7:4] == smcm_pkg::RESP_NO_ERROR)
            && (q.resp[3:0] == $past(q.resp[3:0]) + smcm_pkg::RESP_COUNT_STEP))
        else $error("response counter did not step by one");

    AST_OVERFLOW_FLAG: assert property (
        (q.st == ST_MEAS_WAIT) && adc_done && (adc_data == smcm_pkg::ADC_OVERFLOW) && !gcr_ev
        |=> (q.resp[7:4] != smcm_pkg::RESP_NO_ERROR))
        else $error("overflow not shown in the response");

    AST_RESET_CMD: assert property (s_exec_reset |=> s_off_then_init)
        else $error("reset command did not restart cleanly");

    AST_CLEAR_RESP: assert property (
        (q.st == ST_EXEC) && (cmd_code == smcm_pkg::CMD_CLEAR_RESPONSE) && !gcr_ev
        |=> (q.resp == '0))
        else $error("clear command left the response non-zero");

    AST_PARAM_READ: assert property (
        (q.st == ST_EXEC) && (cmd_op == smcm_pkg::OP_PARAM_READ) && !gcr_ev
        |=> (q.pout == $past(q.pram[cmd_idx])))
        else $error("parameter read returned the wrong entry");

    AST_PARAM_WRITE: assert property (
        (q.st == ST_EXEC) && (cmd_op == smcm_pkg::OP_PARAM_WRITE) && !gcr_ev
        |=> (q.pout == $past(param_in)) && (q.pram[$past(cmd_idx)] == $past(param_in)))
        else $error("parameter write not stored or echoed");

endmodule

// [src/smcm_pkg.sv]
// constants of the mode sequencer; its link-side mailbox uses none of them
package smcm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0] CMD_CLEAR_RESPONSE  = 8'h00;
    localparam logic [7:0] CMD_RESET           = 8'h01;
    localparam logic [7:0] CMD_BUS_ID_CHANGE   = 8'h02;
    localparam logic [7:0] CMD_SINGLE_MEASURE  = 8'h06;
    localparam logic [7:0] CMD_PAUSE_LOOP      = 8'h0A;
    localparam logic [7:0] CMD_AUTONOMOUS_LOOP = 8'h0E;
    localparam logic [2:0] OP_PARAM_READ       = 3'h4;
    localparam logic [2:0] OP_PARAM_WRITE      = 3'h5;
    localparam int         OP_MSB              = 7;
    localparam int         OP_LSB              = 5;
    localparam int         IDX_MSB             = 4;

    ////////////////////////////////////////////////////////////////////////////
    // parameter ram layout
    localparam int         PRAM_DEPTH          = 32;
    localparam logic [4:0] PIDX_CHANNEL_SELECT = 5'h01;
    localparam logic [4:0] PIDX_WAKE_INTERVAL  = 5'h08;
    localparam int         CHSEL_LSB           = 4;
    localparam int         NUM_CH              = 3;

    ////////////////////////////////////////////////////////////////////////////
    // channels and response codes
    localparam logic [1:0]  CH_VISIBLE         = 2'h0;
    localparam logic [1:0]  CH_DONE            = 2'h3;
    localparam logic [15:0] ADC_OVERFLOW       = 16'hFFFF;
    localparam logic [7:0]  RESP_OVF_BASE      = 8'h8C;
    localparam logic [3:0]  RESP_NO_ERROR      = 4'h0;
    localparam logic [3:0]  RESP_COUNT_STEP    = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_FREQ_MHZ       = 50;
    localparam int INIT_TIME_NS       = 2000;
    localparam int INIT_CYCLES_DEF    = (INIT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int WAKE_UNIT_NS       = 31250;
    localparam int WAKE_UNIT_CYC_DEF  = WAKE_UNIT_NS * CLK_FREQ_MHZ / 1000;
    localparam int TMR_W              = 24;

endpackage

// [src/smcm_link.sv]
// link-clock side of the command mailbox with its clock crossings
`timescale 1ns/1ps
module smcm_link (
    // link clock and core reset
    input  wire logic       link_clk,
    input  wire logic       srst,
    // host mailbox writes
    input  wire logic       host_cmd_wr,
    input  wire logic [7:0] host_cmd_code,
    input  wire logic [7:0] host_param_in,
    input  wire logic       host_gen_reset,
    // host mailbox reads
    output logic      [7:0] host_resp,
    output logic      [7:0] host_param_out,
    // toward the core
    output logic      [7:0] cmd_code,
    output logic      [7:0] param_in,
    output logic            req_tgl,
    output logic            gcr_tgl,
    // from the core
    input  wire logic [7:0] core_resp,
    input  wire logic [7:0] core_pout,
    input  wire logic       upd_tgl
);

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [2:0] upd_sync;
        logic [7:0] cmd_code;
        logic [7:0] param_in;
        logic       req_tgl;
        logic       gcr_tgl;
        logic [7:0] resp;
        logic [7:0] pout;
    } smcm_link_state_t;

    smcm_link_state_t q;
    smcm_link_state_t d;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d          = q;
        d.rst_sync = {q.rst_sync[0], srst};
        d.upd_sync = {q.upd_sync[1:0], upd_tgl};
        if (q.rst_sync[1]) begin
            d.cmd_code = '0;
            d.param_in = '0;
            d.req_tgl  = 1'b0;
            d.gcr_tgl  = 1'b0;
            d.resp     = '0;
            d.pout     = '0;
        end else begin
            // command write wakes the core, general-call reset restarts it through off
            if (host_cmd_wr) begin
                d.cmd_code = host_cmd_code;
                d.param_in = host_param_in;
                d.req_tgl  = ~q.req_tgl;
            end
            // general-call reset passed on as an event
            if (host_gen_reset) begin
                d.gcr_tgl = ~q.gcr_tgl;
            end
            if (q.upd_sync[2] ^ q.upd_sync[1]) begin
                d.resp = core_resp;
                d.pout = core_pout;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        q <= d;
    end

    assign host_resp      = q.resp;
    assign host_param_out = q.pout;
    assign cmd_code       = q.cmd_code;
    assign param_in       = q.param_in;
    assign req_tgl        = q.req_tgl;
    assign gcr_tgl        = q.gcr_tgl;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_CMD_WAKES_CORE: assert property (@(posedge link_clk) disable iff (q.rst_sync[1])
        host_cmd_wr |=> (req_tgl != $past(req_tgl)) && (cmd_code == $past(host_cmd_code)))
        else $error("command write did not raise a wake event");

endmodule

// [bench/smcm_adc_model.sv]
// conversion engine model answering each start pulse after a fixed delay
`timescale 1ns/1ps
module smcm_adc_model #(
    parameter int LAT = 3
) (
    // core clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // conversion handshake
    input  wire logic        adc_start,
    input  wire logic [1:0]  adc_chan,
    input  wire logic        ovf,
    output logic             adc_done,
    output logic      [15:0] adc_data
);
    int         cnt;
    logic [1:0] ch;
    always @(posedge clock) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (srst) begin
            cnt <= 0;
            adc_data <= 16'h0000;
        end else if (adc_start) begin
            cnt <= LAT;
            ch <= adc_chan;
        end else if (cnt == 1) begin
            cnt <= 0;
            adc_done <= 1'b1;
            adc_data <= ovf ? 16'hFFFF : 16'h5A00 + 16'(ch);
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// [bench/tb_top.sv]
// self-checking bench of the mode sequencer and command mailbox
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0, link_clk = 1'b0, srst = 1'b1;
    logic host_cmd_wr = 1'b0, host_gen_reset = 1'b0, irq_enable = 1'b0, irq_clear = 1'b0;
    logic ovf = 1'b0;
    logic [7:0] host_cmd_code = 8'h00, host_param_in = 8'h00, host_resp, host_param_out;
    logic int_level, int_oe, adc_start, adc_done, seq_awake, auto_active;
    logic [1:0] adc_chan;
    logic [15:0] adc_data, result_visible, result_infrared, result_third;
    logic [1:0] q[$];
    int err_count = 0, n_compared = 0, cyc = 0;

    always #10 clock = ~clock;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    smcm_core #(.INIT_CYCLES(4), .WAKE_UNIT_CYCLES(8)) smcm_core_inst (
        .clock(clock), .srst(srst), .link_clk(link_clk), .host_cmd_wr(host_cmd_wr),
        .host_cmd_code(host_cmd_code), .host_param_in(host_param_in),
        .host_gen_reset(host_gen_reset), .host_resp(host_resp),
        .host_param_out(host_param_out), .irq_enable(irq_enable), .irq_clear(irq_clear),
        .int_level(int_level), .int_oe(int_oe), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
        .result_visible(result_visible), .result_infrared(result_infrared),
        .result_third(result_third), .seq_awake(seq_awake), .auto_active(auto_active));
    smcm_adc_model smcm_adc_model_inst (
        .clock(clock), .srst(srst), .adc_start(adc_start), .adc_chan(adc_chan),
        .ovf(ovf), .adc_done(adc_done), .adc_data(adc_data));

    always @(posedge clock) begin
        if (adc_start === 1'b1) q.push_back(adc_chan);
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compares and host helpers
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wclk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [7:0] pin);
        @(posedge link_clk);
        #1;
        host_cmd_wr = 1'b1;
        host_cmd_code = code;
        host_param_in = pin;
        @(posedge link_clk);
        #1;
        host_cmd_wr = 1'b0;
    endtask
    task automatic wait_resp(input logic [7:0] exp);
        int n;
        n = 0;
        while (host_resp !== exp && n < 400) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        cmp_val({8'h00, host_resp}, {8'h00, exp});
    endtask
    task automatic wait_sig(input bit pick, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((pick ? int_oe : seq_awake) !== lvl && n < lim) begin
            wclk(1);
            n++;
        end
        cmp_bit(pick ? int_oe : seq_awake, lvl);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_init();
        wait_sig(1'b0, 1'b1, 5);
        wait_sig(1'b0, 1'b0, 50);
        wclk(20); // host settles after init before commands
        cmp_val(16'(q.size()), 16'h0000);
        cmp_val({8'h00, host_resp}, 16'h0000);
        $display("test init done");
    endtask
    task automatic t_param();
        cmd(8'h00, 8'h00);
        wait_resp(8'h00);
        cmd(8'hA1, 8'h50);
        wait_resp(8'h01);
        cmp_val({8'h00, host_param_out}, 16'h0050);
        cmd(8'hA8, 8'h00);
        wait_resp(8'h02);
        cmd(8'h81, 8'h00);
        wait_resp(8'h03);
        cmp_val({8'h00, host_param_out}, 16'h0050);
        $display("test param done");
    endtask
    task automatic t_single();
        irq_enable = 1'b1;
        q.delete();
        cmd(8'h06, 8'h00);
        wait_resp(8'h04);
        wait_sig(1'b1, 1'b1, 200);
        cmp_val(16'(q.size()), 16'h0002);
        cmp_val({14'h0000, q[0]}, 16'h0000);
        cmp_val({14'h0000, q[1]}, 16'h0002);
        cmp_val(result_visible, 16'h5A00);
        cmp_val(result_infrared, 16'h0000);
        cmp_val(result_third, 16'h5A02);
        wclk(30);
        cmp_bit(int_oe, 1'b1);
        cmp_bit(int_level, 1'b0);
        cmp_bit(seq_awake, 1'b0);
        irq_clear = 1'b1;
        wclk(1);
        irq_clear = 1'b0;
        wait_sig(1'b1, 1'b0, 5);
        $display("test single done");
    endtask
    task automatic t_reserved();
        logic [7:0] codes[5] = '{8'h02, 8'h03, 8'h0C, 8'h10, 8'hC5};
        q.delete();
        foreach (codes[i]) begin
            cmd(codes[i], 8'h33);
            repeat (30) @(posedge link_clk);
        end
        cmp_val({8'h00, host_resp}, 16'h0004);
        cmp_val(16'(q.size()), 16'h0000);
        cmd(8'h81, 8'h00);
        wait_resp(8'h05);
        cmp_val({8'h00, host_param_out}, 16'h0050);
        $display("test reserved done");
    endtask
    task automatic t_auto();
        q.delete();
        cmd(8'h0E, 8'h00);
        wait_resp(8'h06);
        cmp_bit(auto_active, 1'b1);
        wclk(100);
        cmp_val(16'(q.size()), 16'h0000);
        cmd(8'h0A, 8'h00);
        wait_resp(8'h07);
        cmd(8'hA8, 8'h02);
        wait_resp(8'h08);
        q.delete();
        cmd(8'h0E, 8'h00);
        wait_resp(8'h09);
        wclk(160);
        cmp_bit(q.size() >= 12, 1'b1);
        cmp_val({14'h0000, q[0]}, 16'h0000);
        cmp_val({14'h0000, q[1]}, 16'h0002);
        cmd(8'h0A, 8'h00);
        wait_resp(8'h0A);
        wclk(40);
        cmp_bit(auto_active, 1'b0);
        q.delete();
        wclk(100);
        cmp_val(16'(q.size()), 16'h0000);
        $display("test auto done");
    endtask
    task automatic t_ovf();
        cmd(8'h00, 8'h00);
        wait_resp(8'h00);
        cmd(8'hA1, 8'h10);
        wait_resp(8'h01);
        ovf = 1'b1;
        cmd(8'h06, 8'h00);
        wait_resp(8'h8C);
        wclk(40);
        ovf = 1'b0;
        cmd(8'h00, 8'h00);
        wait_resp(8'h00);
        $display("test overflow done");
    endtask
    task automatic t_reset();
        cmd(8'h01, 8'h00);
        wait_sig(1'b0, 1'b1, 100);
        #1000000;
        cmp_bit(seq_awake, 1'b0);
        cmp_val(result_visible, 16'h0000);
        cmd(8'h81, 8'h00);
        wait_resp(8'h01);
        cmp_val({8'h00, host_param_out}, 16'h0000);
        cmd(8'h06, 8'h00);
        wait_resp(8'h02);
        wait_sig(1'b1, 1'b1, 50);
        @(posedge link_clk);
        #1;
        host_gen_reset = 1'b1;
        @(posedge link_clk);
        #1;
        host_gen_reset = 1'b0;
        wait_sig(1'b0, 1'b1, 100);
        wait_sig(1'b0, 1'b0, 50);
        cmp_bit(int_oe, 1'b0);
        $display("test reset done");
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        wclk(10);
        srst = 1'b0;
        t_init();
        t_param();
        t_single();
        t_reserved();
        t_auto();
        t_ovf();
        t_reset();
        close_out();
    end
endmodule
